/* verilog/byte_add_with_carry_alu.sv */
// Byte add and add-with-carry unit holding the accumulator and its flags.
// Assumes a data memory read port: data returns the cycle after the read strobe.
// Functional notes
// - Plain add writes source plus accumulator
// - Add with carry includes present carry
// - Carry from bit 7, aux from bit 3
// - Overflow is carry6 xor carry7
// - Register, direct, indirect or immediate source
// - Indirect reads memory at pointer value
// - Opcode 0x34 takes immediate second byte
`timescale 1ns/10ps
module byte_add_with_carry_alu
	import byte_add_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       instr_valid_in,
	input  wire instr_t     instr_in,
	input  wire logic [1:0] bank_sel_in,
	input  wire logic       acc_wr_in,
	input  wire logic [7:0] acc_wr_data_in,
	input  wire logic       flags_wr_in,
	input  wire flags_t     flags_wr_data_in,
	input  wire logic [7:0] mem_data_in,
	output logic            mem_rd_out,
	output logic [7:0]      mem_addr_out,
	output logic [7:0]      acc_out,
	output flags_t          flags_out,
	output logic            busy_out,
	output logic            done_out
);

	typedef enum logic [1:0] {
		S_IDLE,
		S_REQ,
		S_DATA,
		S_EXEC
	} state_t;

	////////////////////////////////////////////////////////////////////////////////
	// Functions
	// Opcode belongs to this unit
	function automatic logic is_add_op(input logic [7:0] op);
		return (op[7:4] == OP_HI_ADD || op[7:4] == OP_HI_ADD_CARRY) &&
			(op[OP_REG_BIT] || op[3:1] == OP_LO_PTR_HI ||
			 op[3:0] == OP_LO_DIRECT || op[3:0] == OP_LO_IMM);
	endfunction

	// Operand mode from low nibble
	function automatic src_mode_t mode_of(input logic [7:0] op);
		if (op[OP_REG_BIT]) begin
			return MODE_REG;
		end else if (op[3:1] == OP_LO_PTR_HI) begin
			return MODE_PTR;
		end else if (op[3:0] == OP_LO_DIRECT) begin
			return MODE_DIRECT;
		end else begin
			return MODE_IMM;
		end
	endfunction

	// Eight-bit add with carry-in and flag generation
	function automatic add_result_t add8(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [8:0]  full;
		logic [4:0]  low;
		logic [7:0]  low7;
		add_result_t r;
		full = {1'b0, a} + {1'b0, b} + {8'h0_000, cin};
		low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0_000, cin};
		low7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h0_000, cin};
		r.sum                  = full[7:0];
		r.flags.carry_flag     = full[BYTE_CARRY];
		r.flags.aux_carry_flag = low[NIBBLE_CARRY];
		r.flags.overflow_flag  = low7[SIGN_BIT] ^ full[BYTE_CARRY];
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State
	state_t      state_reg,    state_next;
	logic        ptr_phase_reg, ptr_phase_next;
	logic        use_cy_reg,   use_cy_next;
	logic [7:0]  src_reg,      src_next;
	logic [7:0]  acc_reg,      acc_next;
	flags_t      flags_reg,    flags_next;
	logic        rd_reg,       rd_next;
	logic [7:0]  addr_reg,     addr_next;
	logic        done_reg,     done_next;
	logic        busy_reg,     busy_next;
	logic        accept;
	src_mode_t   mode;
	add_result_t res;

	assign accept = instr_valid_in && state_reg == S_IDLE && is_add_op(instr_in.opcode);
	assign mode   = mode_of(instr_in.opcode);
	assign res    = add8(acc_reg, src_reg, use_cy_reg && flags_reg.carry_flag);

	// Next-state and datapath logic
	always_comb begin
		state_next     = state_reg;
		ptr_phase_next = ptr_phase_reg;
		use_cy_next    = use_cy_reg;
		src_next       = src_reg;
		acc_next       = acc_wr_in ? acc_wr_data_in : acc_reg;
		flags_next     = flags_wr_in ? flags_wr_data_in : flags_reg;
		rd_next        = 1'b0;
		addr_next      = addr_reg;
		done_next      = 1'b0;
		case (state_reg)
			S_IDLE: begin
				if (accept) begin
					use_cy_next    = instr_in.opcode[7:4] == OP_HI_ADD_CARRY;
					ptr_phase_next = mode == MODE_PTR;
					case (mode)
						MODE_REG: begin
							addr_next  = {3'h0_000, bank_sel_in, instr_in.opcode[2:0]};
							rd_next    = 1'b1;
							state_next = S_REQ;
						end
						MODE_PTR: begin
							addr_next  = {3'h0_000, bank_sel_in, 2'h0_000, instr_in.opcode[0]};
							rd_next    = 1'b1;
							state_next = S_REQ;
						end
						MODE_DIRECT: begin
							addr_next  = instr_in.operand;
							rd_next    = 1'b1;
							state_next = S_REQ;
						end
						default: begin
							src_next   = instr_in.operand;
							state_next = S_EXEC;
						end
					endcase
				end
			end
			S_REQ: begin
				state_next = S_DATA;
			end
			S_DATA: begin
				if (ptr_phase_reg) begin
					addr_next      = mem_data_in;
					rd_next        = 1'b1;
					ptr_phase_next = 1'b0;
					state_next     = S_REQ;
				end else begin
					src_next   = mem_data_in;
					state_next = S_EXEC;
				end
			end
			default: begin
				acc_next   = res.sum;
				flags_next = res.flags;
				done_next  = 1'b1;
				state_next = S_IDLE;
			end
		endcase
		busy_next = state_next != S_IDLE;
	end

	// Registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg     <= S_IDLE;
			ptr_phase_reg <= 1'b0;
			use_cy_reg    <= 1'b0;
			src_reg       <= ACC_RESET;
			acc_reg       <= ACC_RESET;
			flags_reg     <= '0;
			rd_reg        <= 1'b0;
			addr_reg      <= ADDR_RESET;
			done_reg      <= 1'b0;
			busy_reg      <= 1'b0;
		end else begin
			state_reg     <= state_next;
			ptr_phase_reg <= ptr_phase_next;
			use_cy_reg    <= use_cy_next;
			src_reg       <= src_next;
			acc_reg       <= acc_next;
			flags_reg     <= flags_next;
			rd_reg        <= rd_next;
			addr_reg      <= addr_next;
			done_reg      <= done_next;
			busy_reg      <= busy_next;
		end
	end

	// Outputs straight from flops
	assign mem_rd_out   = rd_reg;
	assign mem_addr_out = addr_reg;
	assign acc_out      = acc_reg;
	assign flags_out    = flags_reg;
	assign busy_out     = busy_reg;
	assign done_out     = done_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	logic       exec;
	logic       cin_chk;
	logic [8:0] sum_chk;
	logic [4:0] nib_chk;
	assign exec    = state_reg == S_EXEC;
	assign cin_chk = use_cy_reg && flags_reg.carry_flag;
	assign sum_chk = {1'b0, acc_reg} + {1'b0, src_reg} + {8'h0_000, cin_chk};
	assign nib_chk = {1'b0, acc_reg[3:0]} + {1'b0, src_reg[3:0]} + {4'h0_000, cin_chk};

	sequence s_fetch;
		state_reg == S_REQ ##1 state_reg == S_DATA;
	endsequence

	property p_plain_add;
		@(posedge clk_in) disable iff (rst_in)
		exec && !use_cy_reg |=> acc_out == 8'($past(acc_reg) + $past(src_reg)) && done_out;
	endproperty
	a_plain_add: assert property (p_plain_add) else $error("plain add result wrong");

	property p_carry_add;
		@(posedge clk_in) disable iff (rst_in)
		exec && use_cy_reg |=> acc_out == 8'($past(acc_reg) + $past(src_reg) + $past(cin_chk));
	endproperty
	a_carry_add: assert property (p_carry_add) else $error("carry add result wrong");

	property p_carry_flags;
		@(posedge clk_in) disable iff (rst_in)
		exec |=> flags_out.carry_flag == $past(sum_chk[8]) &&
			flags_out.aux_carry_flag == $past(nib_chk[4]);
	endproperty
	a_carry_flags: assert property (p_carry_flags) else $error("carry flags wrong");

	property p_overflow;
		@(posedge clk_in) disable iff (rst_in)
		exec |=> flags_out.overflow_flag == ($past(acc_reg[7]) == $past(src_reg[7]) &&
			acc_out[7] != $past(acc_reg[7]));
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow flag wrong");

	property p_direct_fetch;
		@(posedge clk_in) disable iff (rst_in)
		accept && mode == MODE_DIRECT |=> mem_rd_out && mem_addr_out == $past(instr_in.operand);
	endproperty
	a_direct_fetch: assert property (p_direct_fetch) else $error("direct fetch wrong");

	property p_indirect;
		@(posedge clk_in) disable iff (rst_in)
		state_reg == S_DATA && ptr_phase_reg |=> (mem_rd_out &&
			mem_addr_out == $past(mem_data_in)) ##0 s_fetch ##1 exec;
	endproperty
	a_indirect: assert property (p_indirect) else $error("indirect fetch wrong");

	property p_immediate;
		@(posedge clk_in) disable iff (rst_in)
		accept && instr_in.opcode == {OP_HI_ADD_CARRY, OP_LO_IMM} |=>
			exec && src_reg == $past(instr_in.operand) && !mem_rd_out ##1 done_out;
	endproperty
	a_immediate: assert property (p_immediate) else $error("immediate form wrong");

	property p_direct_timing;
		@(posedge clk_in) disable iff (rst_in)
		accept && mode == MODE_DIRECT |=> s_fetch ##1 exec ##1 done_out && !busy_out;
	endproperty
	a_direct_timing: assert property (p_direct_timing) else $error("direct timing wrong");

	property p_reg_decode;
		@(posedge clk_in) disable iff (rst_in)
		accept && instr_in.opcode[3] |=> mem_rd_out &&
			mem_addr_out == {3'h0_000, $past(bank_sel_in), $past(instr_in.opcode[2:0])} &&
			use_cy_reg == ($past(instr_in.opcode[7:4]) == OP_HI_ADD_CARRY);
	endproperty
	a_reg_decode: assert property (p_reg_decode) else $error("register decode wrong");

endmodule // byte_add_with_carry_alu

/* verilog/add_with_carry_op_pkg.sv */
// Package for the byte add unit: opcode fields, operand modes, carriers.
// Assumes an eight-bit core with 256-byte internal data memory.
package byte_add_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Opcode fields
	localparam logic [3:0] OP_HI_ADD     = 4'h0_002;
	localparam logic [3:0] OP_HI_ADD_CARRY = 4'h0_003;
	localparam logic [3:0] OP_LO_IMM     = 4'h0_004;
	localparam logic [3:0] OP_LO_DIRECT  = 4'h0_005;
	localparam logic [2:0] OP_LO_PTR_HI  = 3'h0_003;
	localparam int         OP_REG_BIT    = 3;
	localparam int         NIBBLE_CARRY  = 4;
	localparam int         BYTE_CARRY    = 8;
	localparam int         SIGN_BIT      = 7;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] ACC_RESET     = 8'h0_000;
	localparam logic [7:0] ADDR_RESET    = 8'h0_000;

	// Source operand mode
	typedef enum logic [1:0] {
		MODE_REG,
		MODE_PTR,
		MODE_DIRECT,
		MODE_IMM
	} src_mode_t;

	// Instruction as handed over by the decoder
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] operand;
	} instr_t;

	// Arithmetic flags
	typedef struct packed {
		logic carry_flag;
		logic aux_carry_flag;
		logic overflow_flag;
	} flags_t;

	// Full adder outcome
	typedef struct packed {
		logic [7:0] sum;
		flags_t     flags;
	} add_result_t;

endpackage

/* verif/data_mem_model.sv */
// Internal data memory seen from the add unit: one registered read port.
// Assumes the unit strobes a read and takes data on the following cycle.
`timescale 1ns/10ps
module data_mem_model (
	input  wire logic       clk_in,
	input  wire logic       mem_rd_in,
	input  wire logic [7:0] mem_addr_in,
	output logic [7:0]      mem_data_out
);
	logic [7:0] mem [256];

	////////////////////////////////////////////////////////////////////////////////
	// Fixed scattered contents, readable by the bench
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'((i * 73 + 11) ^ (i >> 3));
		end
	end

	// Data valid one cycle after the strobe, otherwise toggling garbage
	always_ff @(posedge clk_in) begin
		if (mem_rd_in) begin
			mem_data_out <= mem[mem_addr_in];
		end else begin
			mem_data_out <= ~mem_data_out;
		end
	end
endmodule // data_mem_model

/* verif/byte_add_with_carry_alu_tb.sv */
// Self-checking bench for the byte add unit with an integer reference model.
// Assumes the data memory model answers every read strobe of the unit.
`timescale 1ns/10ps
module byte_add_with_carry_alu_tb;
	import byte_add_pkg::*;
	logic        clk_in, rst_in, instr_valid_in, acc_wr_in, flags_wr_in;
	logic        mem_rd_out, busy_out, done_out;
	instr_t      instr_in;
	flags_t      flags_wr_data_in, flags_out;
	logic [1:0]  bank_sel_in;
	logic [7:0]  acc_wr_data_in, mem_data_in, mem_addr_out, acc_out;
	logic [31:0] rnd;
	int          miscompares, cmp_count, e_acc, e_cy, e_ac, e_ov;
	int          exp_q[$];

	byte_add_with_carry_alu byte_add_with_carry_alu_inst (.clk_in(clk_in), .rst_in(rst_in),
		.instr_valid_in(instr_valid_in), .instr_in(instr_in), .bank_sel_in(bank_sel_in),
		.acc_wr_in(acc_wr_in), .acc_wr_data_in(acc_wr_data_in), .flags_wr_in(flags_wr_in),
		.flags_wr_data_in(flags_wr_data_in), .mem_data_in(mem_data_in),
		.mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out), .acc_out(acc_out),
		.flags_out(flags_out), .busy_out(busy_out), .done_out(done_out));
	data_mem_model data_mem_model_inst (.clk_in(clk_in), .mem_rd_in(mem_rd_out),
		.mem_addr_in(mem_addr_out), .mem_data_out(mem_data_in));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, 8 ns period
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("compares=%0d mismatches=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Core load of accumulator and flags while idle
	task automatic load(input logic [7:0] a, input logic [2:0] f);
		acc_wr_in = 1'b1;
		acc_wr_data_in = a;
		flags_wr_in = 1'b1;
		flags_wr_data_in = f;
		@(negedge clk_in);
		acc_wr_in = 1'b0;
		flags_wr_in = 1'b0;
		e_acc = a;
		{e_cy, e_ac, e_ov} = {31'd0, f[2], 31'd0, f[1], 31'd0, f[0]};
	endtask

	// Issue one instruction, predict, wait for done, compare
	task automatic run(input logic [7:0] op, input logic [7:0] opd, input logic [1:0] bk);
		int src, c, s, c6, n, lat;
		case (op[3:0]) inside
			4'b1???: src = data_mem_model_inst.mem[bk * 8 + op[2:0]];
			4'b0110, 4'b0111: src = data_mem_model_inst.mem[data_mem_model_inst.mem[bk * 8 + op[0]]];
			4'b0101: src = data_mem_model_inst.mem[opd];
			default: src = opd;
		endcase
		lat = op[3] ? 3 : (op[3:1] == 3'b011) ? 5 : (op[3:0] == 4'b0101) ? 3 : 1;
		c = (op[7:4] == 4'h0_003) ? e_cy : 0;
		s = e_acc + src + c;
		e_ac = int'((e_acc % 16) + (src % 16) + c > 15);
		c6 = int'((e_acc % 128) + (src % 128) + c > 127);
		e_cy = int'(s > 255);
		e_ov = c6 ^ e_cy;
		e_acc = s % 256;
		exp_q.push_back(e_acc);
		instr_valid_in = 1'b1;
		instr_in = '{opcode: op, operand: opd};
		bank_sel_in = bk;
		@(negedge clk_in);
		chk({7'd0, busy_out}, 8'h0_001);
		// Offer another add while busy: it must be ignored
		instr_in.opcode = 8'h0_028;
		n = 0;
		while (done_out !== 1'b1 && n < 10) begin
			@(negedge clk_in);
			n++;
		end
		instr_valid_in = 1'b0;
		chk({7'd0, done_out}, 8'h0_001);
		chk({7'd0, busy_out}, 8'h0_000);
		chk(8'(n), 8'(lat));
		chk(acc_out, 8'(exp_q.pop_front()));
		chk({5'd0, flags_out}, {5'd0, 1'(e_cy), 1'(e_ac), 1'(e_ov)});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst_in, instr_valid_in, acc_wr_in, flags_wr_in} = 4'b1000;
		instr_in = '0;
		bank_sel_in = 2'd0;
		acc_wr_data_in = 8'h0_000;
		flags_wr_data_in = '0;
		rnd = 32'd99595;
		{e_acc, e_cy, e_ac, e_ov} = '0;
		repeat (10) @(negedge clk_in);
		rst_in = 1'b0;
		load(8'h0_0C3, 3'b000);
		run(8'h0_024, 8'h0_0AA, 2'd0);
		load(8'h0_0C3, 3'b100);
		run(8'h0_034, 8'h0_0AA, 2'd0);
		for (int k = 0; k < 80; k++) begin
			rnd = lfsr_next(rnd);
			if (rnd[20]) begin
				load(rnd[31:24], rnd[23:21]);
			end
			case (rnd[2:1])
				2'd0: run({3'b001, rnd[0], 1'b1, rnd[5:3]}, rnd[15:8], rnd[17:16]);
				2'd1: run({3'b001, rnd[0], 3'b011, rnd[3]}, rnd[15:8], rnd[17:16]);
				2'd2: run({3'b001, rnd[0], 4'b0101}, rnd[15:8], rnd[17:16]);
				default: run({3'b001, rnd[0], 4'b0100}, rnd[15:8], rnd[17:16]);
			endcase
		end
		// Foreign opcode must be ignored
		instr_valid_in = 1'b1;
		instr_in = '{opcode: 8'h0_014, operand: 8'h0_055};
		@(negedge clk_in);
		instr_valid_in = 1'b0;
		repeat (8) begin
			@(negedge clk_in);
			chk({7'd0, done_out}, 8'h0_000);
		end
		chk(acc_out, 8'(e_acc));
		tally_and_finish();
	end

	// Watchdog against a hung handshake
	initial begin
		#200000;
		miscompares++;
		tally_and_finish();
	end
endmodule // byte_add_with_carry_alu_tb
